// File: design/irc_divword.sv
// Effective divider word of one divider: bypass or a word of 0 or 1 gives one.
// Assumes the raw divide word and bypass bit are static configuration levels.
`timescale 1ns/1ps
module irc_divword #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Configuration
  input wire logic [WIDTH-1:0] word,
  input wire logic bypass,
  // Result
  output logic [WIDTH-1:0] ratio,
  output logic divide_by_one
);
  localparam logic [WIDTH-1:0] ONE = WIDTH'(1);

  initial begin
    if (WIDTH < 2) $error("irc_divword: WIDTH must be at least 2");
  end

  logic one_nxt;

  assign one_nxt = bypass || (word <= ONE);

  // The ratio leaves a flip-flop so downstream counters see a glitch-free word.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ratio <= ONE;
      divide_by_one <= 1'b1;
    end else begin
      ratio <= one_nxt ? ONE : word;
      divide_by_one <= one_nxt;
    end
  end
endmodule : irc_divword

// File: design/irc_pkg.sv
// Package for the input receiver configuration block: register map, field
// positions, reset values and the packed structs that carry decoded controls.
// Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
package irc_pkg;

  // Printed offsets are not multiples of four, so they are word indices.
  localparam logic [11:0] IRC_IDX_RX_CTRL = 12'h01a;
  localparam logic [11:0] IRC_IDX_MODE_FB = 12'h01b;
  localparam int IRC_ADDR_W = 12;
  localparam int IRC_REG_W = 8;

  // Fields of input_receiver_control.
  localparam int IRC_RX_TEST_EN = 7;
  localparam int IRC_RX_SEC_DIFF = 6;
  localparam int IRC_RX_PRI_DIFF = 5;
  localparam int IRC_RX_SEC_EN = 4;
  localparam int IRC_RX_PRI_EN = 3;
  localparam int IRC_RX_PD_CTRL = 2;
  localparam int IRC_RX_OSC_SEL = 1;
  localparam int IRC_RX_OSC_DIFF = 0;

  // Fields of receiver_mode_and_feedback_control.
  localparam int IRC_MF_TEST_BYP = 7;
  localparam int IRC_MF_FB_BYP = 6;
  localparam int IRC_MF_ZD_INT = 5;
  localparam int IRC_MF_FB_OSC = 4;
  localparam int IRC_MF_ZD_SEL = 3;
  localparam int IRC_MF_ZD_DIFF = 2;
  localparam int IRC_MF_SEC_SEL = 1;
  localparam int IRC_MF_PRI_SEL = 0;

  localparam logic [7:0] IRC_RX_CTRL_RST = 8'h00;
  localparam logic [7:0] IRC_MODE_FB_RST = 8'h00;

  // Divider word widths of the loop's test-reference and feedback dividers.
  localparam int IRC_TEST_DIV_W = 6;
  localparam int IRC_FB_DIV_W = 10;

  localparam logic [1:0] IRC_RESP_OKAY = 2'h0;
  localparam logic [1:0] IRC_RESP_SLVERR = 2'h2;

  // Controls for one analog receiver.
  typedef struct packed {
    logic enable;
    logic differential;
    logic pin_select;
  } irc_rx_ctrl_t;

  // Feedback path selection of the input loop.
  typedef enum logic [1:0] {
    IRC_FB_OSC = 2'b00,
    IRC_FB_ZD_EXT = 2'b01,
    IRC_FB_ZD_INT = 2'b10
  } irc_fb_path_t;

endpackage : irc_pkg

// File: design/irc_top.sv
// Configuration registers and decode for the receivers of the input loop.
// Assumes an AXI4-Lite master on aclk; divider words come from elsewhere.
//
// Notes on behaviour
// - Test-reference receiver enable bit, resets off.
// - Secondary reference differential when mode bit set.
// - Primary reference differential when mode bit set.
// - Power-down control clear keeps both references enabled.
// - Power-down control set: bits 4,3 enable receivers.
// - Oscillator input differential when mode bit set.
// - Single-ended oscillator: set selects negative pin.
// - Bypass bits force test and feedback dividers.
// - Feedback source bit picks oscillator or zero-delay.
// - Zero-delay mode bit picks internal or external.
// - Zero-delay receiver differential when mode bit set.
// - Single-ended zero-delay pin chosen by select bit.
// - Single-ended secondary pin chosen by bit 1.
// - Single-ended primary pin chosen by bit 0.
// - Test-reference divider six bits, one to 63.
// - Feedback divider ten bits, one to 1023.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module irc_top
  import irc_pkg::*;
#(
  parameter int TEST_DIV_W = IRC_TEST_DIV_W,
  parameter int FB_DIV_W = IRC_FB_DIV_W
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Divider words held by the neighbouring registers
  input wire logic [TEST_DIV_W-1:0] test_div_word,
  input wire logic [FB_DIV_W-1:0] fb_div_word,
  // Receiver controls
  output irc_rx_ctrl_t primary_reference_input_ctrl,
  output irc_rx_ctrl_t secondary_reference_input_ctrl,
  output irc_rx_ctrl_t oscillator_input_ctrl,
  output irc_rx_ctrl_t zero_delay_input_ctrl,
  output logic test_reference_input_en,
  // Input loop feedback and dividers
  output irc_fb_path_t input_loop_fb_path,
  output logic [TEST_DIV_W-1:0] test_div_ratio,
  output logic test_div_is_one,
  output logic [FB_DIV_W-1:0] fb_div_ratio,
  output logic fb_div_is_one
);

  initial begin
    if (TEST_DIV_W != IRC_TEST_DIV_W) $error("irc_top: test divider must be 6 bits");
    if (FB_DIV_W != IRC_FB_DIV_W) $error("irc_top: feedback divider must be 10 bits");
  end

  // Word index from a byte address; unaligned bits decode away, high bits must be zero for is_mapped.
  function automatic logic [IRC_ADDR_W-1:0] word_index(input logic [31:0] addr);
    word_index = addr[IRC_ADDR_W+1:2];
  endfunction : word_index

  function automatic logic is_mapped(input logic [31:0] addr);
    logic [IRC_ADDR_W-1:0] idx;
    idx = word_index(addr);
    is_mapped = (addr[31:IRC_ADDR_W+2] == '0)
      && (idx == IRC_IDX_RX_CTRL || idx == IRC_IDX_MODE_FB);
  endfunction : is_mapped

  logic [IRC_REG_W-1:0] rx_ctrl_r;
  logic [IRC_REG_W-1:0] mode_fb_r;

  // Write channel: address and data are latched independently, in either order.
  logic aw_held_r;
  logic w_held_r;
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic wr_go;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign wr_go = aw_held_r && w_held_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 32'h0000_0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= IRC_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= is_mapped(awaddr_r) ? IRC_RESP_OKAY : IRC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Only byte lane 0 carries register bits; other lanes are accepted and dropped.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_ctrl_r <= IRC_RX_CTRL_RST;
    end else if (wr_go && wstrb_r[0] && is_mapped(awaddr_r)
                 && word_index(awaddr_r) == IRC_IDX_RX_CTRL) begin
      rx_ctrl_r <= wdata_r[IRC_REG_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_fb_r <= IRC_MODE_FB_RST;
    end else if (wr_go && wstrb_r[0] && is_mapped(awaddr_r)
                 && word_index(awaddr_r) == IRC_IDX_MODE_FB) begin
      mode_fb_r <= wdata_r[IRC_REG_W-1:0];
    end
  end

  // Read channel: one read under way, answered the cycle after the address.
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= IRC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      // Reads have no side effects; unused upper bits read as zero.
      if (!is_mapped(s_axi_araddr)) begin
        rdata_r <= 32'h0000_0000;
        rresp_r <= IRC_RESP_SLVERR;
      end else if (word_index(s_axi_araddr) == IRC_IDX_RX_CTRL) begin
        rdata_r <= {24'h00_0000, rx_ctrl_r};
        rresp_r <= IRC_RESP_OKAY;
      end else begin
        rdata_r <= {24'h00_0000, mode_fb_r};
        rresp_r <= IRC_RESP_OKAY;
      end
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Receiver decode is combinational from the stored bits.
  logic fb_from_osc;
  logic zd_internal;

  assign fb_from_osc = mode_fb_r[IRC_MF_FB_OSC];
  assign zd_internal = mode_fb_r[IRC_MF_ZD_INT];

  assign test_reference_input_en = rx_ctrl_r[IRC_RX_TEST_EN];

  always_comb begin
    // Until power-down control is armed both references stay on.
    primary_reference_input_ctrl.enable =
      !rx_ctrl_r[IRC_RX_PD_CTRL] || rx_ctrl_r[IRC_RX_PRI_EN];
    primary_reference_input_ctrl.differential = rx_ctrl_r[IRC_RX_PRI_DIFF];
    primary_reference_input_ctrl.pin_select = mode_fb_r[IRC_MF_PRI_SEL];
    secondary_reference_input_ctrl.enable =
      !rx_ctrl_r[IRC_RX_PD_CTRL] || rx_ctrl_r[IRC_RX_SEC_EN];
    secondary_reference_input_ctrl.differential = rx_ctrl_r[IRC_RX_SEC_DIFF];
    secondary_reference_input_ctrl.pin_select = mode_fb_r[IRC_MF_SEC_SEL];
  end

  always_comb begin
    // The oscillator receiver always runs; it also drives the local clock tree.
    oscillator_input_ctrl.enable = 1'b1;
    oscillator_input_ctrl.differential = rx_ctrl_r[IRC_RX_OSC_DIFF];
    // A set select means the negative pin, only meaningful when single-ended.
    oscillator_input_ctrl.pin_select = rx_ctrl_r[IRC_RX_OSC_SEL];
  end

  always_comb begin
    // The zero-delay receiver is needed only for external zero-delay feedback.
    zero_delay_input_ctrl.enable = !fb_from_osc && !zd_internal;
    zero_delay_input_ctrl.differential = mode_fb_r[IRC_MF_ZD_DIFF];
    zero_delay_input_ctrl.pin_select = mode_fb_r[IRC_MF_ZD_SEL];
  end

  always_comb begin
    // The zero-delay mode bit is ignored while the oscillator feeds the loop.
    if (fb_from_osc) begin
      input_loop_fb_path = IRC_FB_OSC;
    end else if (zd_internal) begin
      input_loop_fb_path = IRC_FB_ZD_INT;
    end else begin
      input_loop_fb_path = IRC_FB_ZD_EXT;
    end
  end

  // Effective divide ratios; bypass and words 0 or 1 all mean divide-by-one.
  irc_divword #(
    .WIDTH(TEST_DIV_W)
  ) u_test_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .word(test_div_word),
    .bypass(mode_fb_r[IRC_MF_TEST_BYP]),
    .ratio(test_div_ratio),
    .divide_by_one(test_div_is_one)
  );

  irc_divword #(
    .WIDTH(FB_DIV_W)
  ) u_fb_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .word(fb_div_word),
    .bypass(mode_fb_r[IRC_MF_FB_BYP]),
    .ratio(fb_div_ratio),
    .divide_by_one(fb_div_is_one)
  );

  // Protection bits carry no meaning for this block.
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot, wdata_r[31:IRC_REG_W], wstrb_r[3:1]};

endmodule : irc_top

// File: verification/irc_top_chk.sv
// Port-level checks for irc_top: bus handshakes, feedback decode and dividers.
// Assumes it is bound into irc_top and sees only that module's ports.
`timescale 1ns/1ps
module irc_top_chk
  import irc_pkg::*;
#(
  parameter int TEST_DIV_W = 6,
  parameter int FB_DIV_W = 10
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Dividers
  input wire logic [TEST_DIV_W-1:0] test_div_word,
  input wire logic [TEST_DIV_W-1:0] test_div_ratio,
  input wire logic test_div_is_one,
  input wire logic [FB_DIV_W-1:0] fb_div_word,
  input wire logic [FB_DIV_W-1:0] fb_div_ratio,
  input wire logic fb_div_is_one,
  // Feedback decode
  input wire irc_rx_ctrl_t zero_delay_input_ctrl,
  input wire irc_fb_path_t input_loop_fb_path
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_tdiv;
    test_div_is_one ? test_div_ratio == 1 :
      (test_div_ratio == $past(test_div_word) && $past(test_div_word) > 1);
  endproperty
  a_tdiv: assert property (p_tdiv) else $error("test divider ratio wrong");
  property p_fdiv;
    fb_div_is_one ? fb_div_ratio == 1 :
      (fb_div_ratio == $past(fb_div_word) && $past(fb_div_word) > 1);
  endproperty
  a_fdiv: assert property (p_fdiv) else $error("feedback divider ratio wrong");
  property p_zd_en;
    zero_delay_input_ctrl.enable == (input_loop_fb_path == IRC_FB_ZD_EXT);
  endproperty
  a_zd_en: assert property (p_zd_en) else $error("zero delay enable wrong");
  // A path change without a write commit would mean the decode is not from storage.
  property p_path_wr;
    $changed(input_loop_fb_path) |-> $rose(s_axi_bvalid);
  endproperty
  a_path_wr: assert property (p_path_wr) else $error("path moved without write");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_ar;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar: assert property (p_ar) else $error("read taken while busy");
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
endmodule : irc_top_chk

bind irc_top irc_top_chk #(.TEST_DIV_W(TEST_DIV_W), .FB_DIV_W(FB_DIV_W)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .test_div_word(test_div_word), .test_div_ratio(test_div_ratio),
  .test_div_is_one(test_div_is_one), .fb_div_word(fb_div_word), .fb_div_ratio(fb_div_ratio),
  .fb_div_is_one(fb_div_is_one), .zero_delay_input_ctrl(zero_delay_input_ctrl),
  .input_loop_fb_path(input_loop_fb_path));

// File: verification/testbench.sv
// Random register traffic against irc_top over AXI4-Lite, with decode checks.
// Assumes irc_top_chk is bound in and the register map of irc_pkg.
`timescale 1ns/1ps
module testbench;
  import irc_pkg::*;
  localparam logic [31:0] addr_rx = 32'({IRC_IDX_RX_CTRL, 2'b00});
  localparam logic [31:0] addr_mf = 32'({IRC_IDX_MODE_FB, 2'b00});
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, tone, fone, ten;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [5:0] tword, tratio;
  logic [9:0] fword, fratio;
  logic [7:0] r0, r1;
  irc_rx_ctrl_t pri, sec, osc, zd;
  irc_fb_path_t path;
  int err_total = 0;
  int total_checks = 0;
  logic [9:0] corner [4] = '{10'h000, 10'h001, 10'h3ff, 10'h002};
  wire [14:0] dec_now = {pri, sec, osc, zd, ten, path};
  wire [31:0] div_now = {10'h0, fratio, fone, 4'h0, tratio, tone};

  irc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .test_div_word(tword), .fb_div_word(fword),
    .primary_reference_input_ctrl(pri), .secondary_reference_input_ctrl(sec),
    .oscillator_input_ctrl(osc), .zero_delay_input_ctrl(zd), .test_reference_input_en(ten),
    .input_loop_fb_path(path), .test_div_ratio(tratio), .test_div_is_one(tone),
    .fb_div_ratio(fratio), .fb_div_is_one(fone));

  always #20 aclk = ~aclk;

  task automatic chk_bus(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t bus got %h exp %h", $time, got, exp);
    end
  endtask : chk_bus

  task automatic chk_ctrl(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t ctrl got %h exp %h", $time, got, exp);
    end
  endtask : chk_ctrl

  function automatic logic [14:0] exp_ctrl(input logic [7:0] a, input logic [7:0] b);
    return {!a[2] | a[3], a[5], b[0], !a[2] | a[4], a[6], b[1], 1'b1, a[0], a[1],
      !b[4] & !b[5], b[2], b[3], a[7], b[4] ? IRC_FB_OSC : (b[5] ? IRC_FB_ZD_INT : IRC_FB_ZD_EXT)};
  endfunction : exp_ctrl

  function automatic logic [10:0] exp_div(input logic [9:0] w, input logic byp);
    return (byp || w <= 10'h001) ? {10'h001, 1'b1} : {w, 1'b0};
  endfunction : exp_div

  // Ready is raised only after valid shows, so every answer must stand a cycle.
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      bready <= bvalid && !bready;
    end while (!(bvalid && bready) && n < 100);
    resp = bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
      rready <= rvalid && !rready;
    end while (!(rvalid && rready) && n < 100);
    resp = rresp;
    rd = rdata;
  endtask : axi_rd

  task automatic chk_all(input logic [7:0] a, input logic [7:0] b);
    logic [14:0] e;
    logic [31:0] d;
    @(negedge aclk);
    e = exp_ctrl(a, b);
    d = {10'h0, exp_div(fword, b[6]), exp_div({4'h0, tword}, b[7])};
    chk_ctrl(32'(dec_now[14:9]), 32'(e[14:9]));
    chk_ctrl(32'(dec_now[8:0]), 32'(e[8:0]));
    chk_ctrl(div_now, d);
    axi_rd(addr_rx);
    chk_bus({resp, rd}, {IRC_RESP_OKAY, 24'h0, a});
    axi_rd(addr_mf);
    chk_bus({resp, rd}, {IRC_RESP_OKAY, 24'h0, b});
  endtask : chk_all

  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr, wstrb, tword, fword} = '0;
    r0 = 8'($urandom(83062));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    chk_all(8'h00, 8'h00);
    for (int i = 0; i < 40; i++) begin
      r0 = 8'($urandom);
      r1 = 8'($urandom);
      if (i < 8) begin
        r0 = 8'(i << 2);
        r1 = 8'(i << 4);
      end
      tword <= (i < 4) ? corner[i][5:0] : 6'($urandom);
      fword <= (i < 4) ? corner[i] : 10'($urandom);
      axi_wr(addr_rx, {24'($urandom), r0}, 4'h1);
      chk_bus({resp, 32'h0}, {IRC_RESP_OKAY, 32'h0});
      axi_wr(addr_mf, {24'($urandom), r1}, 4'h1);
      chk_bus({resp, 32'h0}, {IRC_RESP_OKAY, 32'h0});
      chk_all(r0, r1);
    end
    axi_wr(32'h70, 32'hff, 4'h1);
    chk_bus({resp, 32'h0}, {IRC_RESP_SLVERR, 32'h0});
    axi_wr(addr_rx, {24'h0, ~r0}, 4'h0);
    chk_bus({resp, 32'h0}, {IRC_RESP_OKAY, 32'h0});
    axi_rd(32'h70);
    chk_bus({resp, rd}, {IRC_RESP_SLVERR, 32'h0});
    chk_all(r0, r1);
    aresetn <= 1'b0;
    tword <= 6'h00;
    fword <= 10'h000;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    chk_all(8'h00, 8'h00);
    conclude();
  end

  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    conclude();
  end
endmodule : testbench
